// [eeprom_defines.svh]
// Timing counts and field positions for the serial EEPROM erase/write block.
// Assumes a 125 MHz core clock sampling all serial pins.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define CLK_PERIOD_NS 8
`define PROG_TIME_NS 10000000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_WORDS_X8 256
`define NUM_WORDS_X16 128
`define ADDR_BITS_X8 8
`define ADDR_BITS_X16 7
`define DATA_BITS_X8 8
`define DATA_BITS_X16 16
`define ERASED_WORD 16'hffff

`endif

// [eeprom_pkg.sv]
// Types shared by the serial EEPROM erase/write block.
// Assumes nothing of its surroundings.
package eeprom_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_READ,
    OP_WRITE,
    OP_ERASE,
    OP_ERASE_ALL,
    OP_WRITE_ALL,
    OP_WEN,
    OP_WDS
  } op_t;
endpackage

// [pin_sync.sv]
// Two-flop synchroniser for one pin, with edge flags decoded combinationally from the synchronised and previous levels.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ns
module pin_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// [prog_timer.sv]
// Self-timed nonvolatile cycle counter.
// Assumes start is a one-cycle pulse; busy rises the cycle after it.
`timescale 1ns/1ns
`include "eeprom_defines.svh"
module prog_timer #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [23:0] count_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= 24'h000000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        count_q <= 24'(PROG_CYCLES - 1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (count_q == 24'h000000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 24'h000001;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule

// [eeprom_ctrl.sv]
// Serial EEPROM instruction decoder with erase, write, enable/disable, erase-all,
// write-all, read and ready/busy polling on the data-out pin.
// Assumes the host drives chip select, serial clock and data in; all pins are async.
//
// Notes on behaviour
// [RULE1] Erase starts on chip-select falling edge
// [RULE2] Self-timed cycle needs no serial clock
// [RULE3] Reselect during cycle polls ready/busy
// [RULE4] Erased word reads all ones
// [RULE5] Write-enable latch clear at power-up
// [RULE6] Writes refused until write-enable instruction
// [RULE7] Latch stays set until disable or reset
// [RULE8] Latch clear ignores all modifying instructions
// [RULE9] Reads work regardless of latch
// [RULE10] Erase-all starts on chip-select falling edge
// [RULE11] Erase-all leaves whole array all ones
// [RULE12] Write-all stores word everywhere, self-timed
// [RULE13] Write-all needs no prior erase-all
// [RULE14] Width pin selects x8 or x16 fields
// [RULE15] Polling: low busy, high ready
// [RULE16] Start bit, opcode, address, data on rises
// [RULE17] Dummy one releases data-out on fall
// [RULE18] Instructions during busy cycle rejected
`timescale 1ns/1ns
`include "eeprom_defines.svh"
module eeprom_ctrl
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic word_width_select,
  output logic data_out,
  output logic data_out_en,
  output logic busy
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_READ,
    ST_ARMED,
    ST_POLL,
    ST_DONE,
    ST_IGNORE
  } state_t;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic clk_lvl;
  logic clk_rise;
  logic clk_fall;
  logic sdata_lvl;
  logic width_lvl;

  pin_sync u_cs (
    .clock(clock),
    .reset(reset),
    .pin(chip_select),
    .level(cs_lvl),
    .rise(cs_rise),
    .fall(cs_fall)
  );
  pin_sync u_link_clk (
    .clock(clock),
    .reset(reset),
    .pin(serial_clock_in),
    .level(clk_lvl),
    .rise(clk_rise),
    .fall(clk_fall)
  );
  pin_sync u_sdata (
    .clock(clock),
    .reset(reset),
    .pin(serial_data_in),
    .level(sdata_lvl),
    .rise(),
    .fall()
  );
  pin_sync u_width (
    .clock(clock),
    .reset(reset),
    .pin(word_width_select),
    .level(width_lvl),
    .rise(),
    .fall()
  );

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] mem_q [0:`NUM_WORDS_X8-1];
  logic [4:0] shift_cnt_q;
  logic [26:0] shift_q;
  logic wen_q;
  logic [7:0] addr_q;
  logic [15:0] wdata_q;
  op_t pend_q;
  state_t state_q;
  logic [15:0] rd_q;
  logic [4:0] rd_cnt_q;
  logic do_q;
  logic do_en_q;
  logic started_q;

  // x16 mode: 2 opcode + 7 addr; x8: 2 opcode + 8 addr
  function automatic logic [4:0] hdr_len(input logic wide);
    hdr_len = wide ? 5'(2 + `ADDR_BITS_X16) : 5'(2 + `ADDR_BITS_X8);
  endfunction

  function automatic logic [4:0] data_len(input logic wide);
    data_len = wide ? 5'(`DATA_BITS_X16) : 5'(`DATA_BITS_X8);
  endfunction

  // Sequential read wraps at the top of the address space of the current width
  function automatic logic [7:0] step_addr(input logic [7:0] a, input logic wide_mode);
    step_addr = wide_mode ? {1'b0, a[6:0] + 7'h01} : a + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic wide;
  logic [4:0] hlen;
  logic [4:0] dlen;
  logic [1:0] opc;
  logic [7:0] addr_f;
  logic [1:0] sub_f;
  logic hdr_full;
  logic needs_data;
  op_t dec_op;
  logic [15:0] data_f;
  logic timer_busy;
  logic timer_done;
  logic start_pulse;
  logic start_bit;
  logic [7:0] next_addr;

  assign wide = width_lvl; // [RULE14]
  assign start_bit = cs_lvl && clk_rise && sdata_lvl;
  assign next_addr = step_addr(addr_q, wide);
  assign hlen = hdr_len(wide);
  assign dlen = data_len(wide);
  assign opc = wide ? shift_q[8:7] : shift_q[9:8];
  assign addr_f = wide ? {1'b0, shift_q[6:0]} : shift_q[7:0];
  assign sub_f = wide ? shift_q[6:5] : shift_q[7:6];
  assign hdr_full = (shift_cnt_q == hlen);
  assign dec_op = (opc == 2'b10) ? OP_READ :
                  (opc == 2'b01) ? OP_WRITE :
                  (opc == 2'b11) ? OP_ERASE :
                  (sub_f == 2'b11) ? OP_WEN :
                  (sub_f == 2'b00) ? OP_WDS :
                  (sub_f == 2'b10) ? OP_ERASE_ALL : OP_WRITE_ALL; // [RULE16]
  assign needs_data = (dec_op == OP_WRITE) || (dec_op == OP_WRITE_ALL);
  assign data_f = wide ? shift_q[15:0] : {8'h00, shift_q[7:0]};
  // Modifying ops only armed with latch set; reads unaffected
  assign start_pulse = (state_q == ST_ARMED) && cs_fall; // [RULE1] [RULE10] [RULE12]

  prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (.clock(clock), .reset(reset),
    .start(start_pulse), .busy(timer_busy), .done(timer_done)); // [RULE2]

  ////////////////////////////////////////////////////////////////////////
  // Instruction state machine
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      shift_cnt_q <= 5'h00;
      shift_q <= 27'h0000000;
      wen_q <= 1'b0; // [RULE5]
      addr_q <= 8'h00;
      wdata_q <= 16'h0000;
      pend_q <= OP_NONE;
      rd_q <= 16'h0000;
      rd_cnt_q <= 5'h00;
      do_q <= 1'b0;
      do_en_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          do_en_q <= 1'b0;
          shift_cnt_q <= 5'h00;
          started_q <= 1'b0;
          if (start_bit) begin
            state_q <= ST_SHIFT; // [RULE16]
          end
        end
        ST_SHIFT: begin
          if (clk_fall) begin
            do_en_q <= 1'b0; // [RULE17]
          end
          if (!cs_lvl) begin
            state_q <= ST_IDLE;
          end else if (clk_rise) begin
            shift_q <= {shift_q[25:0], sdata_lvl};
            shift_cnt_q <= shift_cnt_q + 5'h01;
          end else if (hdr_full && !started_q) begin
            started_q <= 1'b1;
            addr_q <= addr_f;
            pend_q <= dec_op;
            shift_cnt_q <= needs_data ? (5'h00 - dlen) : 5'h00;
            if (dec_op == OP_READ) begin
              rd_q <= mem_q[addr_f]; // [RULE9]
              rd_cnt_q <= 5'h00;
              state_q <= ST_READ;
            end else if (dec_op == OP_WEN) begin
              wen_q <= 1'b1; // [RULE7]
              state_q <= ST_IGNORE;
            end else if (dec_op == OP_WDS) begin
              wen_q <= 1'b0;
              state_q <= ST_IGNORE;
            end else if (!wen_q) begin
              state_q <= ST_IGNORE; // [RULE6] [RULE8]
            end else if (!needs_data) begin
              state_q <= ST_ARMED;
            end
          end else if (started_q && shift_cnt_q == 5'h00) begin
            wdata_q <= data_f;
            state_q <= ST_ARMED;
          end
        end
        ST_READ: begin
          if (!cs_lvl) begin
            do_en_q <= 1'b0;
            state_q <= ST_IDLE;
          end else if (clk_rise) begin
            do_en_q <= 1'b1;
            if (rd_cnt_q == 5'h00) begin
              do_q <= 1'b0;
            end else begin
              do_q <= wide ? rd_q[15] : rd_q[7];
              rd_q <= {rd_q[14:0], 1'b0};
            end
            if (rd_cnt_q == dlen) begin
              rd_cnt_q <= 5'h01;
              addr_q <= next_addr;
              rd_q <= mem_q[next_addr];
            end else begin
              rd_cnt_q <= rd_cnt_q + 5'h01;
            end
          end
        end
        ST_ARMED: begin
          if (cs_fall) begin
            state_q <= ST_POLL;
          end else if (cs_lvl && clk_rise) begin
            state_q <= ST_IGNORE; // Extra clocks before deselect abort the operation
          end
        end
        ST_POLL: begin
          // Data-out mirrors ready/busy while selected
          if (cs_rise) begin
            do_en_q <= 1'b1; // [RULE3]
          end else if (!cs_lvl) begin
            do_en_q <= 1'b0;
          end
          do_q <= 1'b0; // [RULE15]
          if (timer_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Ready stays pending across deselect, so a late reselect still sees it
          do_q <= 1'b1; // [RULE15]
          if (start_bit) begin
            // The dummy one doubles as the start bit; data-out drops on the next fall
            shift_cnt_q <= 5'h00;
            started_q <= 1'b0;
            state_q <= ST_SHIFT;
          end else if (cs_lvl) begin
            do_en_q <= 1'b1; // [RULE3]
          end else begin
            do_en_q <= 1'b0;
          end
        end
        ST_IGNORE: begin
          // Rest of a finished or refused frame is dropped so its bits never look like a start
          do_en_q <= 1'b0;
          if (!cs_lvl) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array update; busy state refuses new instructions since only ST_POLL runs
  always_ff @(posedge clock) begin
    if (timer_done) begin // [RULE18]
      for (int i = 0; i < `NUM_WORDS_X8; i++) begin
        if (pend_q == OP_ERASE_ALL) begin
          mem_q[i] <= `ERASED_WORD; // [RULE11]
        end else if (pend_q == OP_WRITE_ALL && (!wide || i < `NUM_WORDS_X16)) begin
          mem_q[i] <= wdata_q; // [RULE12] [RULE13]
        end else if (8'(i) == addr_q) begin
          if (pend_q == OP_ERASE) begin
            mem_q[i] <= `ERASED_WORD; // [RULE4]
          end else if (pend_q == OP_WRITE) begin
            mem_q[i] <= wdata_q;
          end
        end
      end
    end
  end

  assign data_out = do_q;
  assign data_out_en = do_en_q;
  assign busy = timer_busy;
endmodule

// [eeprom_ctrl_asserts.sv]
// Pin-level checks for the serial EEPROM erase/write controller.
// Assumes PROG_CYCLES matches the design instance it is bound to.
`timescale 1ns/1ns
module eeprom_ctrl_asserts #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic word_width_select,
  input wire logic data_out,
  input wire logic data_out_en,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  assign busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clock) begin
    busy_cnt_q <= reset ? 32'h0 : busy_cnt_d;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_cs_drop;
    $fell(chip_select);
  endsequence
  sequence s_poll_open;
    busy && $rose(chip_select);
  endsequence
  // Reset itself is the antecedent here, so the default disable must not apply
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !busy && !data_out_en)
    else $error("outputs active after reset");
  a_start_on_drop: assert property ($rose(busy) |-> !chip_select && $past(chip_select, 12))
    else $error("cycle started without a chip select drop");
  a_cycle_length: assert property ($fell(busy) |-> busy_cnt_q + 1 >= PROG_CYCLES && busy_cnt_q <= PROG_CYCLES + 1)
    else $error("self-timed cycle has wrong length");
  a_poll_enable: assert property (s_poll_open |-> ##[1:6] data_out_en)
    else $error("status not driven on reselect");
  a_poll_low: assert property (busy && $past(busy) && data_out_en |-> !data_out)
    else $error("status high while busy");
  a_ready_high: assert property ($fell(busy) && data_out_en |-> ##[0:3] data_out)
    else $error("status not high after cycle end");
  a_release_deselect: assert property (s_cs_drop |-> ##[1:6] !data_out_en)
    else $error("data out driven while deselected");
  a_no_restart: assert property ($fell(busy) |=> !busy [*8])
    else $error("new cycle began straight after the last");
endmodule
bind eeprom_ctrl eeprom_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_ctrl_asserts (.clock(clock), .reset(reset),
  .chip_select(chip_select), .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
  .word_width_select(word_width_select), .data_out(data_out), .data_out_en(data_out_en), .busy(busy));

// [serial_host.sv]
// Behavioural host driving the three-wire serial bus, 125 ns serial clock.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
module serial_host (
  input wire logic clock,
  input wire logic data_out,
  input wire logic data_out_en,
  output logic chip_select,
  output logic serial_clock_in,
  output logic serial_data_in
);
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // Data out is taken at the clock fall, long after the rise updates it
  task automatic pulse(input logic b, output logic seen);
    serial_data_in = b;
    #62 serial_clock_in = 1'b1;
    #63 serial_clock_in = 1'b0;
    seen = data_out;
  endtask
  task automatic frame(input logic [1:0] op, input logic [7:0] a, input int na, input logic [15:0] d, input int nd);
    logic s;
    chip_select = 1'b1;
    #100;
    pulse(1'b1, s);
    for (int i = 1; i >= 0; i--) pulse(op[i], s);
    for (int i = na - 1; i >= 0; i--) pulse(a[i], s);
    for (int i = nd - 1; i >= 0; i--) pulse(d[i], s);
  endtask
  // Data in is flipped so a stale level is never mistaken for a held one
  task automatic deselect();
    chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    #260;
  endtask
  task automatic read_word(input logic [7:0] a, input int na, input int nd, output logic [15:0] d);
    logic s;
    d = 16'h0;
    frame(2'b10, a, na, 16'h0, 0);
    // One extra clock for the leading dummy zero, which shifts out of the top in x16 and stays a zero above the data in x8
    for (int i = 0; i <= nd; i++) begin
      pulse(1'b0, s);
      d = {d[14:0], s};
    end
    deselect();
  endtask
  task automatic poll(output logic early, output logic late, output logic held);
    chip_select = 1'b1;
    #100 early = data_out_en && !data_out;
    for (int i = 0; i < 1000 && data_out !== 1'b1; i++) @(posedge clock);
    late = data_out;
    pulse(1'b1, held);
    #60 held = data_out_en;
    deselect();
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the serial EEPROM erase/write controller.
// Assumes the host model owns the serial pins; reset and width come from here.
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic word_width_select = 1'b1;
  logic chip_select, serial_clock_in, serial_data_in, data_out, data_out_en, busy;
  logic [15:0] fill;
  logic [7:0] addr;
  int miscompares = 0;
  int samples_checked = 0;
  always #4 clock = ~clock;
  eeprom_ctrl #(.PROG_CYCLES(200)) i_eeprom_ctrl (.clock(clock), .reset(reset), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .word_width_select(word_width_select),
    .data_out(data_out), .data_out_en(data_out_en), .busy(busy));
  serial_host i_serial_host (.clock(clock), .data_out(data_out), .data_out_en(data_out_en),
    .chip_select(chip_select), .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in));
  ////////////////////////////////////////////////////////////////
  function automatic int na();
    return word_width_select ? 7 : 8;
  endfunction
  function automatic int nd();
    return word_width_select ? 16 : 8;
  endfunction
  // Sub-opcode sits in the top two address bits
  function automatic logic [7:0] sub(input logic [1:0] s);
    return word_width_select ? {1'b0, s, 5'h0} : {s, 6'h0};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic modify(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d, input logic runs);
    logic e, l, h;
    i_serial_host.frame(op, a, na(), d, (op == 2'b01 || (op == 2'b00 && a == sub(2'b01))) ? nd() : 0);
    i_serial_host.deselect();
    if (runs) begin
      i_serial_host.poll(e, l, h);
      check({15'h0, e}, 16'h1);
      check({15'h0, l}, 16'h1);
      check({15'h0, h}, 16'h0);
      if (l !== 1'b1) give_verdict();
    end else begin
      repeat (40) @(negedge clock);
      check({15'h0, busy}, 16'h0);
    end
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] got;
    i_serial_host.read_word(a, na(), nd(), got);
    check(got, exp & (word_width_select ? 16'hffff : 16'h00ff));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h18ea));
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    fill = 16'($urandom);
    addr = 8'($urandom) & 8'h7f;
    modify(2'b00, sub(2'b01), fill, 1'b0);
    modify(2'b00, sub(2'b11), 16'h0, 1'b0);
    modify(2'b00, sub(2'b01), fill, 1'b1);
    rd_check(8'($urandom) & 8'h7f, fill);
    modify(2'b11, addr, 16'h0, 1'b1);
    rd_check(addr, 16'hffff);
    rd_check(addr ^ 8'h01, fill);
    modify(2'b00, sub(2'b00), 16'h0, 1'b0);
    modify(2'b00, sub(2'b10), 16'h0, 1'b0);
    modify(2'b11, addr ^ 8'h01, 16'h0, 1'b0);
    rd_check(addr ^ 8'h01, fill);
    modify(2'b00, sub(2'b11), 16'h0, 1'b0);
    modify(2'b00, sub(2'b10), 16'h0, 1'b1);
    rd_check(8'($urandom) & 8'h7f, 16'hffff);
    @(negedge clock);
    word_width_select = 1'b0;
    repeat (8) @(negedge clock);
    fill = {8'h0, 8'($urandom)};
    addr = 8'($urandom);
    modify(2'b00, sub(2'b01), fill, 1'b1);
    rd_check(8'hff, fill);
    modify(2'b01, addr, fill ^ 16'h00ff, 1'b1);
    rd_check(addr, fill ^ 16'h00ff);
    rd_check(addr ^ 8'h01, fill);
    give_verdict();
  end
endmodule
